// ==== include/oswc_pkg.sv ====
// How it works
// - Setting the soft reset request starts a global shutdown that powers down both sequencers and then asserts the system reset, while writing zero has no effect.
// - When soft reset and power off are requested together, only the soft reset path runs, reset included.
// - The soft reset request bit clears itself when the shutdown it started is complete.
// - Setting the power off request starts a global shutdown of both sequencers without any reset.
// - The power off request bit clears itself when the shutdown it started is complete.
// - The three-bit hold time code selects 2, 3, 4, 5, 6, 8, 10 or 12 seconds of manual reset hold.
// - With sleep enabled a low sleep control pin puts the host into sleep, otherwise the pin is ignored.
// - The power-on pin gets only debounce, plus one more second when the extra delay bit is set.
// - A manual reset event wakes the device to ON only while its wake enable is set.
// - A soft reset event wakes the device to ON only while its wake enable is set.
// - A valid main battery event wakes the device only while the battery wake enable is set.
// - The first RTC alarm wakes the device only while its wake enable is set.
// - The second RTC alarm wakes the device only while its wake enable is set.
// - A power-on pin event wakes the device only while its wake enable is set.
package oswc_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] OSWC_CTL1_ADDR = 8'h93;
   localparam logic [7:0] OSWC_WAKE_ADDR = 8'h94;

   // Control one fields
   localparam int OSWC_SFT_BIT  = 6;
   localparam int OSWC_HOLD_LSB = 3;
   localparam int OSWC_SLP_BIT  = 2;
   localparam int OSWC_OFF_BIT  = 1;
   localparam int OSWC_DLY_BIT  = 0;

   // Wake enable fields
   localparam int OSWC_WK_MR    = 7;
   localparam int OSWC_WK_SFT   = 6;
   localparam int OSWC_WK_WD    = 5;
   localparam int OSWC_WK_CHG   = 4;
   localparam int OSWC_WK_BATT  = 3;
   localparam int OSWC_WK_ALMA  = 2;
   localparam int OSWC_WK_ALMB  = 1;
   localparam int OSWC_WK_PON   = 0;

   // Reset values of fixed bits; bits 7 and 3 come from module parameters
   localparam logic [7:0] OSWC_WAKE_RST   = 8'h47;
   localparam logic [7:0] OSWC_WAKE_OTPM  = 8'h88;
   localparam logic [7:0] OSWC_CTL1_OTPM  = 8'h39;

   // ==========================================================
   // Timing
   localparam int unsigned OSWC_CLK_HZ        = 40_000_000;
   localparam int unsigned OSWC_EXTRA_DELAY_S = 1;
   localparam int unsigned OSWC_CYC_PER_SEC   = OSWC_EXTRA_DELAY_S * OSWC_CLK_HZ;
   localparam int unsigned OSWC_DEBOUNCE_US   = 30_000;
   localparam int unsigned OSWC_DEBOUNCE_CYC  = OSWC_DEBOUNCE_US * (OSWC_CLK_HZ / 1_000_000);
   localparam logic [7:0]  OSWC_RST_PULSE_CYC = 8'h10;
   localparam logic [3:0]  OSWC_HOLD_S [8]    = '{4'h2, 4'h3, 4'h4, 4'h5,
                                                  4'h6, 4'h8, 4'ha, 4'hc};

   // ==========================================================
   // Types
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_PWRDN = 3'b010,
      ST_RST   = 3'b100
   } oswc_sd_state_t;

   typedef enum logic [1:0]
   {
      CAUSE_OFF  = 2'h0,
      CAUSE_SOFT = 2'h1,
      CAUSE_MR   = 2'h2,
      CAUSE_WD   = 2'h3
   } oswc_cause_t;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } oswc_reg_req_t;

   typedef struct packed
   {
      logic wd_reset;
      logic charger_ok;
      logic main_battery;
      logic rtc_alarm_a;
      logic rtc_alarm_b;
   } oswc_evt_t;

   typedef struct packed
   {
      logic [31:0] cnt;
      logic        hit;
   } oswc_tmr_state_t;

   typedef struct packed
   {
      oswc_sd_state_t st;
      oswc_cause_t    cause;
      logic [7:0]     ctl1;
      logic [7:0]     wake_en;
      logic [7:0]     rdata;
      logic [7:0]     rst_cnt;
      logic           dev_on;
      logic           wake;
      logic           sleep;
   } oswc_main_state_t;

endpackage

// ==== hdl/oswc_timer.sv ====
`timescale 1ns/1ps
module oswc_timer
(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        run_in,
   input  wire logic [31:0] limit_in,
   output logic             hit_out
);
   import oswc_pkg::*;

   oswc_tmr_state_t s_q;
   oswc_tmr_state_t s_d;

   // ==========================================================
   // Count while run holds, pulse once on reaching the limit
   always_comb
   begin
      s_d     = s_q;
      s_d.hit = 1'b0;
      if (!run_in)
      begin
         s_d.cnt = 32'h0;
      end
      else if (s_q.cnt < limit_in)
      begin
         s_d.cnt = s_q.cnt + 32'h1;
         s_d.hit = (s_q.cnt + 32'h1 == limit_in);
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign hit_out = s_q.hit;

endmodule

// ==== hdl/oswc_onoff_ctrl.sv ====
`timescale 1ns/1ps
module oswc_onoff_ctrl
#(
   parameter int unsigned CYC_PER_SEC  = oswc_pkg::OSWC_CYC_PER_SEC,
   parameter int unsigned DEBOUNCE_CYC = oswc_pkg::OSWC_DEBOUNCE_CYC,
   parameter logic [2:0]  HOLD_RESET   = 3'h0,
   parameter logic        DLY_RESET    = 1'b0,
   parameter logic        WK_MR_RESET  = 1'b0,
   parameter logic        WK_BAT_RESET = 1'b0
)
(
   input  wire logic                   clk_in,
   input  wire logic                   arst_n_in,
   input  wire oswc_pkg::oswc_reg_req_t reg_req_in,
   output logic [7:0]                  reg_rdata_out,
   input  wire logic                   manual_reset_pin_n_in,
   input  wire logic                   power_on_pin_in,
   input  wire logic                   sleep_control_pin_n_in,
   input  wire oswc_pkg::oswc_evt_t     evt_in,
   input  wire logic                   sequencer_a_done_in,
   input  wire logic                   sequencer_b_done_in,
   output logic                        sequencer_a_pwrdn_out,
   output logic                        sequencer_b_pwrdn_out,
   output logic                        sys_reset_out,
   output logic                        host_sleep_out,
   output logic                        wakeup_out,
   output logic                        device_on_out
);
   import oswc_pkg::*;

   // ==========================================================
   // Elaboration checks
   if (CYC_PER_SEC == 0 || CYC_PER_SEC > 32'd300_000_000)
   begin : g_chk_sec
      $error("CYC_PER_SEC out of range");
   end
   if (DEBOUNCE_CYC == 0 || DEBOUNCE_CYC > 32'd100_000_000)
   begin : g_chk_deb
      $error("DEBOUNCE_CYC out of range");
   end

   oswc_main_state_t s_q;
   oswc_main_state_t s_d;
   logic [31:0]      hold_cyc;
   logic [31:0]      pon_cyc;
   logic             mr_hit;
   logic             pon_hit;
   logic             evt_wake;
   logic             end_sd;
   logic             wake_end;
   oswc_sd_state_t   st_d;

   // ==========================================================
   // Manual reset hold time decode
   always_comb
   begin
      hold_cyc = 32'(OSWC_HOLD_S[s_q.ctl1[OSWC_HOLD_LSB +: 3]]) * 32'(CYC_PER_SEC);
   end

   // Power-on pin qualification time
   always_comb
   begin
      pon_cyc = 32'(DEBOUNCE_CYC);
      if (s_q.ctl1[OSWC_DLY_BIT])
      begin
         pon_cyc = 32'(DEBOUNCE_CYC) + 32'(CYC_PER_SEC);
      end
   end

   // Manual reset hold timer
   oswc_timer u_mr_tmr
   (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .run_in    (~manual_reset_pin_n_in),
      .limit_in  (hold_cyc),
      .hit_out   (mr_hit)
   );

   // Power-on pin debounce and extra delay
   oswc_timer u_pon_tmr
   (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .run_in    (power_on_pin_in),
      .limit_in  (pon_cyc),
      .hit_out   (pon_hit)
   );

   // ==========================================================
   // Standby wake sources, each gated by its enable
   always_comb
   begin
      evt_wake = 1'b0;
      if (evt_in.charger_ok && s_q.wake_en[OSWC_WK_CHG])
      begin
         evt_wake = 1'b1;
      end
      if (evt_in.main_battery && s_q.wake_en[OSWC_WK_BATT])
      begin
         evt_wake = 1'b1;
      end
      if (evt_in.rtc_alarm_a && s_q.wake_en[OSWC_WK_ALMA])
      begin
         evt_wake = 1'b1;
      end
      if (evt_in.rtc_alarm_b && s_q.wake_en[OSWC_WK_ALMB])
      begin
         evt_wake = 1'b1;
      end
      if (pon_hit && s_q.wake_en[OSWC_WK_PON])
      begin
         evt_wake = 1'b1;
      end
   end

   // Wake decision at the end of a shutdown, by cause
   always_comb
   begin
      case (s_q.cause)
         CAUSE_SOFT: wake_end = s_q.wake_en[OSWC_WK_SFT];
         CAUSE_MR:   wake_end = s_q.wake_en[OSWC_WK_MR];
         CAUSE_WD:   wake_end = s_q.wake_en[OSWC_WK_WD];
         default:    wake_end = 1'b0;
      endcase
   end

   // ==========================================================
   // Shutdown sequence
   always_comb
   begin
      st_d   = s_q.st;
      end_sd = 1'b0;
      case (s_q.st)
         ST_IDLE:
         begin
            if (s_q.ctl1[OSWC_SFT_BIT] || mr_hit || evt_in.wd_reset
                || s_q.ctl1[OSWC_OFF_BIT])
            begin
               st_d = ST_PWRDN;
            end
         end
         ST_PWRDN:
         begin
            if (sequencer_a_done_in && sequencer_b_done_in)
            begin
               if (s_q.cause == CAUSE_OFF)
               begin
                  st_d   = ST_IDLE;
                  end_sd = 1'b1;
               end
               else
               begin
                  st_d = ST_RST;
               end
            end
         end
         ST_RST:
         begin
            if (s_q.rst_cnt == OSWC_RST_PULSE_CYC - 8'h1)
            begin
               st_d   = ST_IDLE;
               end_sd = 1'b1;
            end
         end
         default:
         begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Next state of the whole block
   always_comb
   begin
      s_d      = s_q;
      s_d.st   = st_d;
      s_d.wake = 1'b0;

      // Latch cause on start; soft reset outranks power off
      if (s_q.st == ST_IDLE && st_d == ST_PWRDN)
      begin
         if (s_q.ctl1[OSWC_SFT_BIT])
         begin
            s_d.cause = CAUSE_SOFT;
         end
         else if (mr_hit)
         begin
            s_d.cause = CAUSE_MR;
         end
         else if (evt_in.wd_reset)
         begin
            s_d.cause = CAUSE_WD;
         end
         else
         begin
            s_d.cause = CAUSE_OFF;
         end
      end

      // Reset pulse counter
      if (s_q.st == ST_RST)
      begin
         s_d.rst_cnt = s_q.rst_cnt + 8'h1;
      end
      else
      begin
         s_d.rst_cnt = 8'h0;
      end

      // Shutdown complete: self clear requests, go to ON or standby
      if (end_sd)
      begin
         s_d.ctl1[OSWC_SFT_BIT] = 1'b0;
         s_d.ctl1[OSWC_OFF_BIT] = 1'b0;
         s_d.dev_on             = wake_end;
         s_d.wake               = wake_end;
      end
      else if (s_q.st == ST_PWRDN && st_d == ST_PWRDN)
      begin
         s_d.dev_on = 1'b0;
      end
      else if (s_q.st == ST_IDLE && st_d == ST_IDLE && !s_q.dev_on && evt_wake)
      begin
         s_d.dev_on = 1'b1;
         s_d.wake   = 1'b1;
      end

      // Sleep request from the pin
      s_d.sleep = s_q.ctl1[OSWC_SLP_BIT] && !sleep_control_pin_n_in;

      // Register writes; a new request wins over the self clear
      if (reg_req_in.wr)
      begin
         case (reg_req_in.addr)
            OSWC_CTL1_ADDR:
            begin
               s_d.ctl1[7]              = 1'b0;
               s_d.ctl1[OSWC_SFT_BIT]   = s_d.ctl1[OSWC_SFT_BIT]
                                          | reg_req_in.wdata[OSWC_SFT_BIT];
               s_d.ctl1[OSWC_HOLD_LSB +: 3] = reg_req_in.wdata[OSWC_HOLD_LSB +: 3];
               s_d.ctl1[OSWC_SLP_BIT]   = reg_req_in.wdata[OSWC_SLP_BIT];
               s_d.ctl1[OSWC_OFF_BIT]   = s_d.ctl1[OSWC_OFF_BIT]
                                          | reg_req_in.wdata[OSWC_OFF_BIT];
               s_d.ctl1[OSWC_DLY_BIT]   = reg_req_in.wdata[OSWC_DLY_BIT];
            end
            OSWC_WAKE_ADDR:
            begin
               s_d.wake_en = reg_req_in.wdata;
            end
            default:
            begin
               s_d.wake_en = s_q.wake_en;
            end
         endcase
      end

      // Register reads, unmapped address returns zero
      if (reg_req_in.rd)
      begin
         case (reg_req_in.addr)
            OSWC_CTL1_ADDR: s_d.rdata = s_q.ctl1;
            OSWC_WAKE_ADDR: s_d.rdata = s_q.wake_en;
            default:        s_d.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s_q         <= '0;
         s_q.st      <= ST_IDLE;
         s_q.cause   <= CAUSE_OFF;
         s_q.ctl1    <= {2'h0, HOLD_RESET, 2'h0, DLY_RESET};
         s_q.wake_en <= OSWC_WAKE_RST | {WK_MR_RESET, 3'h0, WK_BAT_RESET, 3'h0};
         s_q.dev_on  <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_out         = s_q.rdata;
   assign sequencer_a_pwrdn_out = (s_q.st == ST_PWRDN);
   assign sequencer_b_pwrdn_out = (s_q.st == ST_PWRDN);
   assign sys_reset_out         = (s_q.st == ST_RST);
   assign host_sleep_out        = s_q.sleep;
   assign wakeup_out            = s_q.wake;
   assign device_on_out         = s_q.dev_on;

endmodule

// ==== sim/oswc_seq_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Two power-down sequencers facing the controller
module oswc_seq_model
(
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic [7:0] dly_in,
   input  wire logic       pwrdn_a_in,
   input  wire logic       pwrdn_b_in,
   output logic            done_a_out,
   output logic            done_b_out
);
   logic [7:0] cnt_q;
   // Cycles spent in the current power-down
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) cnt_q <= 8'h00;
      else cnt_q <= pwrdn_a_in ? cnt_q + 8'h01 : 8'h00;
   // Second sequencer lags the first by three cycles
   assign done_a_out = pwrdn_a_in && cnt_q >= dly_in;
   assign done_b_out = pwrdn_b_in && cnt_q >= dly_in + 8'h03;
endmodule

// ==== sim/oswc_onoff_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker for the on/off control
module oswc_onoff_chk
(
   input wire logic                    clk_in,
   input wire logic                    arst_n_in,
   input wire oswc_pkg::oswc_reg_req_t reg_req_in,
   input wire logic [7:0]              reg_rdata_out,
   input wire logic                    sleep_control_pin_n_in,
   input wire logic                    sequencer_a_done_in,
   input wire logic                    sequencer_b_done_in,
   input wire logic                    sequencer_a_pwrdn_out,
   input wire logic                    sequencer_b_pwrdn_out,
   input wire logic                    sys_reset_out,
   input wire logic                    host_sleep_out,
   input wire logic                    wakeup_out,
   input wire logic                    device_on_out
);
   import oswc_pkg::*;
   logic [7:0] rst_len_q;
   // Length of the running reset pulse
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) rst_len_q <= 8'h00;
      else rst_len_q <= sys_reset_out ? rst_len_q + 8'h01 : 8'h00;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // ==========================================
   // Shutdown
   shut_start_a: assert property (reg_req_in.wr && reg_req_in.addr == OSWC_CTL1_ADDR
      && (reg_req_in.wdata[OSWC_SFT_BIT] || reg_req_in.wdata[OSWC_OFF_BIT])
      && !sequencer_a_pwrdn_out && !sys_reset_out |-> ##2 sequencer_a_pwrdn_out)
      else $error("shutdown did not start");
   pwrdn_pair_a: assert property (sequencer_a_pwrdn_out == sequencer_b_pwrdn_out)
      else $error("power-down requests differ");
   pwrdn_end_a: assert property ($fell(sequencer_a_pwrdn_out) |->
      $past(sequencer_a_done_in && sequencer_b_done_in)) else $error("early power-down end");
   rst_after_a: assert property ($rose(sys_reset_out) |-> $past(sequencer_b_pwrdn_out))
      else $error("reset before power-down");
   rst_len_a: assert property ($fell(sys_reset_out) |-> rst_len_q == OSWC_RST_PULSE_CYC)
      else $error("reset pulse length wrong");
   rst_max_a: assert property (rst_len_q <= OSWC_RST_PULSE_CYC)
      else $error("reset pulse too long");
   // ==========================================
   // Wake, sleep and register port
   wake_pulse_a: assert property (wakeup_out |=> !wakeup_out)
      else $error("wake pulse too long");
   wake_on_a: assert property (wakeup_out |-> device_on_out)
      else $error("wake without ON");
   sleep_off_a: assert property ($past(sleep_control_pin_n_in) |-> !host_sleep_out)
      else $error("sleep with pin high");
   unmapped_rd_a: assert property (reg_req_in.rd && reg_req_in.addr != OSWC_CTL1_ADDR
      && reg_req_in.addr != OSWC_WAKE_ADDR |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
      else $error("read data moved");
   c_rst: cover property ($rose(sys_reset_out));
   c_wake: cover property (wakeup_out);
   c_sleep: cover property (host_sleep_out);
endmodule
bind oswc_onoff_ctrl oswc_onoff_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
   .sleep_control_pin_n_in(sleep_control_pin_n_in), .sequencer_a_done_in(sequencer_a_done_in),
   .sequencer_b_done_in(sequencer_b_done_in), .sequencer_a_pwrdn_out(sequencer_a_pwrdn_out),
   .sequencer_b_pwrdn_out(sequencer_b_pwrdn_out), .sys_reset_out(sys_reset_out),
   .host_sleep_out(host_sleep_out), .wakeup_out(wakeup_out), .device_on_out(device_on_out));

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
// ==========================================
// Bench for the on/off control
module tb_top;
   import oswc_pkg::*;
   logic          clk_in = 1'b0, arst_n_in = 1'b0, mr_n = 1'b1, pon = 1'b0, slp_n = 1'b1;
   oswc_reg_req_t req = '0;
   oswc_evt_t     evt = '0;
   logic [7:0]    rdata, dly = 8'h01;
   logic          da, db, pa, pb, rst, slp, wup, on;
   int            n_fail = 0, compares = 0, i, k;
   int            hold_s [8] = '{2, 3, 4, 5, 6, 8, 10, 12};
   always #12.5 clk_in = ~clk_in;
   oswc_onoff_ctrl #(.CYC_PER_SEC(10), .DEBOUNCE_CYC(4)) dut
   (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .manual_reset_pin_n_in(mr_n), .power_on_pin_in(pon), .sleep_control_pin_n_in(slp_n),
      .evt_in(evt), .sequencer_a_done_in(da), .sequencer_b_done_in(db),
      .sequencer_a_pwrdn_out(pa), .sequencer_b_pwrdn_out(pb), .sys_reset_out(rst),
      .host_sleep_out(slp), .wakeup_out(wup), .device_on_out(on)
   );
   oswc_seq_model seq (.clk_in(clk_in), .arst_n_in(arst_n_in), .dly_in(dly),
      .pwrdn_a_in(pa), .pwrdn_b_in(pb), .done_a_out(da), .done_b_out(db));
   // ==========================================
   // Helpers
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Register access; a read compares against d
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      req = '{w, !w, a, w ? d : 8'h00};
      step();
      req = '0;
      if (!w) chk(rdata, d);
      step();
   endtask
   // Follow one shutdown, count reset cycles, check final ON state
   task automatic sd(input int er, input logic eon);
      int r;
      r = 0;
      for (i = 0; i < 300 && !pa; i++) step();
      for (; i < 300 && (pa || rst); i++)
      begin
         step();
         r += int'(rst);
      end
      if (i >= 300)
      begin
         n_fail++;
         finish_test();
      end
      chk(r, er);
      step();
      chk(on, eon);
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk_in);
      #1;
      arst_n_in = 1'b1;
      chk({on, pa, rst, slp, wup}, 5'h10);
      acc(1, 8'h95, 8'hff);
      acc(0, OSWC_CTL1_ADDR, 8'h00);
      acc(0, OSWC_WAKE_ADDR, OSWC_WAKE_RST);
      acc(0, 8'h95, 8'h00);
      $display("test registers done");
      slp_n = 1'b0;
      step(2);
      chk(slp, 0);
      acc(1, OSWC_CTL1_ADDR, 8'h04);
      chk(slp, 1);
      slp_n = 1'b1;
      step(2);
      chk(slp, 0);
      $display("test sleep done");
      acc(1, OSWC_CTL1_ADDR, 8'h00);
      step(4);
      chk(pa, 0);
      acc(1, OSWC_CTL1_ADDR, 8'h40);
      sd(16, 1);
      acc(0, OSWC_CTL1_ADDR, 8'h00);
      acc(1, OSWC_CTL1_ADDR, 8'h42);
      sd(16, 1);
      acc(0, OSWC_CTL1_ADDR, 8'h00);
      dly = 8'd25;
      acc(1, OSWC_CTL1_ADDR, 8'h02);
      sd(0, 0);
      acc(0, OSWC_CTL1_ADDR, 8'h00);
      $display("test shutdown done");
      // Standby: events with wake disabled, then one by one enabled
      acc(1, OSWC_WAKE_ADDR, 8'h00);
      evt = 5'h0f;
      pon = 1'b1;
      step(20);
      chk(on, 0);
      evt = '0;
      pon = 1'b0;
      for (k = 0; k < 4; k++)
      begin
         acc(1, OSWC_WAKE_ADDR, 8'h02 << k);
         evt = 5'h01 << k;
         step();
         evt = '0;
         chk({wup, on}, 2'b11);
         acc(1, OSWC_CTL1_ADDR, 8'h02);
         sd(0, 0);
      end
      dly = 8'h01;
      for (k = 0; k < 2; k++)
      begin
         acc(1, OSWC_WAKE_ADDR, k ? 8'h20 : 8'h00);
         evt = 5'h10;
         step();
         evt = '0;
         sd(16, k[0]);
      end
      acc(1, OSWC_WAKE_ADDR, 8'h00);
      acc(1, OSWC_CTL1_ADDR, 8'h40);
      sd(16, 0);
      $display("test wake done");
      // Manual reset hold time for every code
      for (k = 0; k < 8; k++)
      begin
         acc(1, OSWC_CTL1_ADDR, 8'(k << 3));
         acc(1, OSWC_WAKE_ADDR, {k == 7, 7'h00});
         mr_n = 1'b0;
         for (i = 0; i < 200 && !pa; i++) step();
         mr_n = 1'b1;
         chk(i >= hold_s[k] * 10 && i <= hold_s[k] * 10 + 5, 1);
         if (i >= 200) finish_test();
         sd(16, k == 7);
      end
      $display("test manual reset done");
      // Power-on pin with and without the extra second
      acc(1, OSWC_CTL1_ADDR, 8'h02);
      sd(0, 0);
      acc(1, OSWC_WAKE_ADDR, 8'h01);
      for (k = 0; k < 2; k++)
      begin
         acc(1, OSWC_CTL1_ADDR, 8'(k));
         pon = 1'b1;
         for (i = 0; i < 100 && !wup; i++) step();
         pon = 1'b0;
         chk(i >= 4 + 10 * k && i <= 9 + 10 * k, 1);
         if (i >= 100) finish_test();
         acc(1, OSWC_CTL1_ADDR, 8'h02);
         sd(0, 0);
      end
      $display("test power-on pin done");
      // Reset in the middle of a power-off shutdown
      dly = 8'd25;
      acc(1, OSWC_CTL1_ADDR, 8'h02);
      chk(pa, 1);
      arst_n_in = 1'b0;
      step(3);
      chk({on, pa, rst, slp, wup}, 5'h10);
      arst_n_in = 1'b1;
      step(2);
      chk({on, pa, rst, slp, wup}, 5'h10);
      acc(0, OSWC_CTL1_ADDR, 8'h00);
      acc(0, OSWC_WAKE_ADDR, OSWC_WAKE_RST);
      $display("test mid reset done");
      finish_test();
   end
endmodule
